//--- src/abc_dev.sv
// abc_dev: control and three-state output logic of the converter.
// assumes all control pins synchronous to clk_sys; comparator comes in on comp_in.
// Functional notes
// - last of enable or select starts convert
// - both active: read if high, else convert
// - host lowers read_conv before selecting
// - standalone: ties fixed, read_conv controls alone
// - standalone: outputs on high, falling starts
// - low pulse: float, valid after conversion
// - status rises 200ns, falls 600ns after
// - high pulse: drive only while high
// - status marks busy, starts ignored meanwhile
// - outputs may enable 1.2us before status; here data valid leads the status fall by 600ns
// - byte addr low 12-bit, high 8-bit
// - read: addr 0 msbs, 1 lsbs
// - word format low bytes, high word
// - even byte holds bits 11..4
// - odd byte holds bits 3..0, zeros
// - host masks unused bits on 16-bit
// - host reads only after completion
`timescale 1ns/100ps
module abc_dev
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic comp_in,
  output logic      conv_done,
  abc_if.dev        bus
);
  import abc_pkg::*;

  logic       sel_act;
  logic       sel_act_q;
  logic       rc_q;
  logic       start_req;
  logic       seq_busy;
  logic       seq_done;
  logic [11:0] seq_result;
  logic [2:0] div_q;
  logic       step_en;
  logic       wait_rise_q;
  logic [7:0] rise_cnt_q;
  logic [7:0] fall_cnt_q;
  logic       in_cycle_q;
  logic       data_valid_q;
  abc_op_t    op;

  // ****************************************
  // decode
  // ****************************************
  assign sel_act = bus.chip_en && !bus.chip_sel_n;

  always_comb
  begin
    op = ABC_OP_NONE;
    if (sel_act)
      op = bus.read_conv ? ABC_OP_READ : ABC_OP_CONVERT;
  end

  // ****************************************
  // start detect
  // ****************************************
  // start on the edge of the last select, or read_conv falling while selected
  // read_conv high at select time reads first; the host must lower it
  assign start_req = (op == ABC_OP_CONVERT) && (!sel_act_q || rc_q)
                     && !in_cycle_q && !seq_busy;

  // previous select and read_conv make the start edges
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_act_q <= 1'b0;
      rc_q      <= 1'b0;
    end
    else
    begin
      sel_act_q <= sel_act;
      rc_q      <= bus.read_conv;
    end
  end

  // ****************************************
  // step divider
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 3'h0;
    else
      div_q <= (div_q == 3'(STEP_DIV - 1)) ? 3'h0 : div_q + 3'h1;
  end
  // free running: the first step lands one to STEP_DIV clocks after start
  assign step_en = (div_q == 3'h0);

  // ****************************************
  // conversion cycle and status
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_cycle_q   <= 1'b0;
      wait_rise_q  <= 1'b0;
      rise_cnt_q   <= 8'h00;
      fall_cnt_q   <= 8'h00;
      bus.conv_status <= 1'b0;
      data_valid_q <= 1'b0;
      conv_done    <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (start_req)
      begin
        in_cycle_q   <= 1'b1;
        // status rise runs off its own count, not the step grid
        wait_rise_q  <= 1'b1;
        rise_cnt_q   <= 8'(STS_RISE_CYC - 1);
        data_valid_q <= 1'b0;
      end
      else if (in_cycle_q)
      begin
        if (wait_rise_q)
        begin
          if (rise_cnt_q == 8'h00)
          begin
            wait_rise_q     <= 1'b0;
            bus.conv_status <= 1'b1;
          end
          else
            rise_cnt_q <= rise_cnt_q - 8'h01;
        end
        // data valid opens the early-enable window before status falls
        if (seq_done)
        begin
          data_valid_q <= 1'b1;
          fall_cnt_q   <= 8'(STS_FALL_CYC - 1);
        end
        else if (data_valid_q && !wait_rise_q)
        begin
          // status drops a fixed time after data valid, giving early enable
          if (fall_cnt_q == 8'h00)
          begin
            bus.conv_status <= 1'b0;
            in_cycle_q      <= 1'b0;
            conv_done       <= 1'b1;
          end
          else
            fall_cnt_q <= fall_cnt_q - 8'h01;
        end
      end
    end
  end

  // sequencer takes the conversion length from byte_addr_sel at the start
  abc_sar_seq #(.W(RESULT_W)) abc_sar_seq_i
  (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .start      (start_req),
    .short_conv (bus.byte_addr_sel),
    .step_en    (step_en),
    .comp_in    (comp_in),
    .busy       (seq_busy),
    .done       (seq_done),
    .result     (seq_result)
  );

  // ****************************************
  // output buffers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // every lane floats until a read selects it
      bus.data_out <= RESULT_RST;
      bus.data_oe  <= 12'h000;
    end
    else
    begin
      bus.data_oe <= 12'h000;
      // result held after cycle ends; read mid-cycle floats until valid
      if (op == ABC_OP_READ && (data_valid_q || !in_cycle_q))
      begin
        if (bus.word_fmt)
        begin
          bus.data_out <= seq_result;
          bus.data_oe  <= 12'hFFF;
        end
        // both bytes share lanes 7..0 so an 8-bit bus needs no extra buffers
        else if (!bus.byte_addr_sel)
        begin
          bus.data_out <= {4'h0, seq_result[11:4]};
          bus.data_oe  <= 12'h0FF;
        end
        else
        begin
          bus.data_out <= {4'h0, seq_result[3:0], TRAIL_ZEROS};
          bus.data_oe  <= 12'h0FF;
        end
      end
    end
  end
endmodule

//--- inc/abc_pkg.sv
// abc_pkg: constants shared by the converter control ends, the sequencer and the testbench.
// assumes a single 25 MHz system clock; converter clock steps come from a divider.
package abc_pkg;

  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned RESULT_W       = 12;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned FULL_STEPS     = 12;
  localparam int unsigned SHORT_STEPS    = 8;
  localparam int unsigned STEP_DIV       = 8;
  // timing figures in ns, cycle counts derived from the clock rate
  localparam int unsigned STS_RISE_NS    = 200;
  localparam int unsigned STS_FALL_NS    = 600;
  localparam int unsigned EARLY_EN_NS    = 1200;
  localparam int unsigned STS_RISE_CYC   = (STS_RISE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STS_FALL_CYC   = (STS_FALL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned EARLY_EN_CYC   = (EARLY_EN_NS * CLK_MHZ) / 1000;
  localparam logic [11:0] RESULT_RST     = 12'h000;
  localparam logic [3:0]  TRAIL_ZEROS    = 4'h0;

  typedef enum logic [1:0] {
    ABC_OP_NONE,
    ABC_OP_CONVERT,
    ABC_OP_READ
  } abc_op_t;

endpackage

//--- inc/abc_if.sv
// abc_if: pins between the converter control logic and its controlling party.
// data bus is three-state; data_out and data_oe stay separate and the testbench checks each.
`timescale 1ns/100ps
interface abc_if;
  logic        chip_en;
  logic        chip_sel_n;
  logic        read_conv;
  logic        byte_addr_sel;
  logic        word_fmt;
  logic        conv_status;
  logic [11:0] data_out;
  logic [11:0] data_oe;

  modport dev
  (
    input  chip_en,
    input  chip_sel_n,
    input  read_conv,
    input  byte_addr_sel,
    input  word_fmt,
    output conv_status,
    output data_out,
    output data_oe
  );

  modport host
  (
    output chip_en,
    output chip_sel_n,
    output read_conv,
    output byte_addr_sel,
    output word_fmt,
    input  conv_status,
    input  data_out,
    input  data_oe
  );
endinterface

//--- src/abc_sar_seq.sv
// abc_sar_seq: successive approximation sequencer, one bit per step pulse.
// assumes the comparator input is synchronous to clk_sys.
`timescale 1ns/100ps
module abc_sar_seq
#(
  parameter int unsigned W = 12
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic         short_conv,
  input  wire logic         step_en,
  input  wire logic         comp_in,
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      result
);
  import abc_pkg::*;

  logic [3:0]   bit_q;
  logic [3:0]   last_q;
  logic [W-1:0] trial_q;

  // ****************************************
  // bit walk
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy    <= 1'b0;
      done    <= 1'b0;
      bit_q   <= 4'h0;
      last_q  <= 4'h0;
      trial_q <= '0;
      result  <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy    <= 1'b1;
        bit_q   <= 4'(W - 1);
        last_q  <= short_conv ? 4'(W - SHORT_STEPS) : 4'h0;
        trial_q <= '0;
        trial_q[W-1] <= 1'b1;
      end
      else if (busy && step_en)
      begin
        // msb first; comparator keeps or drops the trial bit
        if (!comp_in)
          trial_q[bit_q] <= 1'b0;
        if (bit_q == last_q)
        begin
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= comp_in ? trial_q : (trial_q & ~(W'(1) << bit_q));
        end
        else
        begin
          bit_q <= bit_q - 4'h1;
          trial_q[bit_q - 4'h1] <= 1'b1;
        end
      end
    end
  end
endmodule

//--- src/abc_host.sv
// abc_host: controlling party; issues a convert, waits on status, reads bytes or word.
// assumes the device end is joined through abc_if.
`timescale 1ns/100ps
module abc_host
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic        short_conv,
  input  wire logic        word_mode,
  output logic             busy,
  output logic             rd_valid,
  output logic [11:0]      rd_data,
  abc_if.host              bus
);
  import abc_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_CONV, H_WAIT_HI, H_WAIT_LO, H_RD0, H_RD1, H_DONE
  } abc_hst_t;

  abc_hst_t   st_q;
  logic [1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q              <= H_IDLE;
      cnt_q             <= 2'h0;
      busy              <= 1'b0;
      rd_valid          <= 1'b0;
      rd_data           <= 12'h000;
      bus.chip_en       <= 1'b0;
      bus.chip_sel_n    <= 1'b1;
      bus.read_conv     <= 1'b0;
      bus.byte_addr_sel <= 1'b0;
      bus.word_fmt      <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      case (st_q)
        H_IDLE:
          if (go)
          begin
            busy              <= 1'b1;
            bus.read_conv     <= 1'b0;
            bus.byte_addr_sel <= short_conv;
            bus.word_fmt      <= word_mode;
            bus.chip_en       <= 1'b1;
            st_q              <= H_CONV;
          end
        H_CONV:
        begin
          bus.chip_sel_n <= 1'b0;
          st_q           <= H_WAIT_HI;
        end
        H_WAIT_HI:
        begin
          bus.chip_sel_n <= 1'b1;
          bus.chip_en    <= 1'b0;
          if (bus.conv_status)
            st_q <= H_WAIT_LO;
        end
        H_WAIT_LO:
          if (!bus.conv_status)
          begin
            bus.read_conv     <= 1'b1;
            bus.byte_addr_sel <= 1'b0;
            bus.chip_en       <= 1'b1;
            bus.chip_sel_n    <= 1'b0;
            cnt_q             <= 2'h2;
            st_q              <= H_RD0;
          end
        H_RD0:
          if (cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
          else if (bus.word_fmt)
          begin
            rd_data  <= bus.data_out;
            rd_valid <= 1'b1;
            st_q     <= H_DONE;
          end
          else
          begin
            rd_data[11:4]     <= bus.data_out[7:0];
            bus.byte_addr_sel <= 1'b1;
            cnt_q             <= 2'h2;
            st_q              <= H_RD1;
          end
        H_RD1:
          if (cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
          else
          begin
            rd_data[3:0] <= bus.data_out[7:4];
            rd_valid     <= 1'b1;
            st_q         <= H_DONE;
          end
        H_DONE:
        begin
          bus.chip_en       <= 1'b0;
          bus.chip_sel_n    <= 1'b1;
          bus.read_conv     <= 1'b0;
          bus.byte_addr_sel <= 1'b0;
          busy              <= 1'b0;
          st_q              <= H_IDLE;
        end
        default:
          st_q <= H_IDLE;
      endcase
    end
  end
endmodule

//--- verif/abc_sva.sv
// abc_sva: timing and lane checks on the pins between host and device ends.
// assumes one abc_if whose signals are handed in by name.
`timescale 1ns/100ps
module abc_sva
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        chip_en,
  input wire logic        chip_sel_n,
  input wire logic        read_conv,
  input wire logic        byte_addr_sel,
  input wire logic        word_fmt,
  input wire logic        conv_status,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] hi_q;
  // counter keeps the cycle bound off a long repetition
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      hi_q <= 8'h00;
    else if (conv_status)
      hi_q <= hi_q + 8'h01;
    else
      hi_q <= 8'h00;
  sequence conv_start;
    $rose(chip_en && !chip_sel_n && !read_conv) && !conv_status;
  endsequence
  sequence status_wait;
    (!conv_status)[*4] ##[1:4] conv_status;
  endsequence
  a_start_rise : assert property (conv_start |-> status_wait)
    else $error("status late after start");
  a_status_hold : assert property ($rose(conv_status) |-> conv_status[*8])
    else $error("status dropped early");
  // short cycle 68..75 clocks high, full 100..107, by step phase at start
  a_cycle_len : assert property ($fell(conv_status) |-> hi_q >= 8'h44 && hi_q <= 8'h6B)
    else $error("conversion length off");
  a_float_start : assert property (conv_start |=> (data_oe == 12'h000)[*4])
    else $error("outputs driven during start");
  a_oe_on_read : assert property (data_oe != 12'h000 |-> $past(chip_en && !chip_sel_n && read_conv))
    else $error("outputs driven without read");
  a_word_lanes : assert property (data_oe != 12'h000 && $past(word_fmt) |-> data_oe == 12'hFFF)
    else $error("word lanes wrong");
  a_byte_lanes : assert property (data_oe != 12'h000 && !$past(word_fmt) |-> data_oe == 12'h0FF)
    else $error("byte lanes wrong");
  a_lsb_zeros : assert property (data_oe != 12'h000 && !$past(word_fmt)
    && $past(byte_addr_sel) |-> data_out[3:0] == 4'h0)
    else $error("low nibble not zero");
  a_reset_idle : assert property ($rose(rst_n) |-> !conv_status && data_oe == 12'h000)
    else $error("not idle after reset");
  a_read_after : assert property ($rose(chip_en && !chip_sel_n && read_conv) |-> !conv_status)
    else $error("read while converting");
endmodule

//--- verif/adc_bus_control_logic_tb.sv
// adc_bus_control_logic_tb: host and device joined, plus a bench-driven device.
// assumes comparator inputs held steady through each conversion.
`timescale 1ns/100ps
module adc_bus_control_logic_tb;
  import abc_pkg::*;
  // ********
  // ends
  // ********
  logic        clk_sys;
  logic        rst_n;
  logic        comp_a;
  logic        comp_b;
  logic        go;
  logic        short_conv;
  logic        word_mode;
  logic        busy;
  logic        rd_valid;
  logic [11:0] rd_data;
  logic        done_b;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc = 0;
  abc_if       bus_a();
  abc_if       bus_b();
  abc_dev abc_dev_i (.clk_sys, .rst_n, .comp_in(comp_a), .conv_done(), .bus(bus_a));
  abc_dev abc_dev_i2 (.clk_sys, .rst_n, .comp_in(comp_b), .conv_done(done_b), .bus(bus_b));
  abc_host abc_host_i (.clk_sys, .rst_n, .go, .short_conv, .word_mode, .busy, .rd_valid,
    .rd_data, .bus(bus_a));
  abc_sva abc_sva_i (.clk_sys, .rst_n, .chip_en(bus_a.chip_en), .chip_sel_n(bus_a.chip_sel_n),
    .read_conv(bus_a.read_conv), .byte_addr_sel(bus_a.byte_addr_sel), .word_fmt(bus_a.word_fmt),
    .conv_status(bus_a.conv_status), .data_out(bus_a.data_out), .data_oe(bus_a.data_oe));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d bad %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // pins in order: enable, select_n, read_conv, byte addr, word format
  task automatic drive(input logic [4:0] p);
    {bus_b.chip_en, bus_b.chip_sel_n, bus_b.read_conv, bus_b.byte_addr_sel, bus_b.word_fmt} = p;
  endtask
  task automatic wait_on(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 400)
    begin
      tick(1);
      k++;
    end
  endtask
  // off: cycles already spent since the start was driven
  task automatic conv_len(input int steps, input int off, input string what);
    int k;
    int e;
    // first step lands 1..STEP_DIV clocks after start; done seen half a clock late
    e = int'((steps - 1) * STEP_DIV + STS_FALL_CYC + 3) - off;
    wait_on(done_b, 1'b1, k);
    check(what, 12'(k >= e && k < e + int'(STEP_DIV)), 12'h001);
  endtask
  task automatic t_host();
    int k;
    for (int m = 0; m < 4; m++)
    begin
      comp_a = (m != 2);
      short_conv = m[0];
      word_mode = m[1];
      go = 1'b1;
      tick(1);
      go = 1'b0;
      wait_on(rd_valid, 1'b1, k);
      check("host_rd", rd_data, !comp_a ? 12'h000 : (m[0] ? 12'hFF0 : 12'hFFF));
      wait_on(busy, 1'b0, k);
    end
    $display("t_host over");
  endtask
  task automatic t_select();
    for (int i = 0; i < 2; i++)
    begin
      drive(i ? 5'h19 : 5'h03);
      tick(4);
      check("sel_none", 12'(bus_b.conv_status), 12'h000);
      drive(i ? 5'h11 : 5'h13);
      conv_len(i ? FULL_STEPS : SHORT_STEPS, 0, "sel_len");
    end
    drive(5'h14);
    tick(2);
    check("msb_oe", bus_b.data_oe, 12'h0FF);
    check("msb", {4'h0, bus_b.data_out[7:0]}, 12'h0FF);
    drive(5'h16);
    tick(2);
    check("lsb", {4'h0, bus_b.data_out[7:0]}, 12'h0F0);
    $display("t_select over");
  endtask
  task automatic t_low_pulse();
    int k;
    drive(5'h15);
    tick(2);
    drive(5'h11);
    tick(1);
    drive(5'h15);
    tick(1);
    check("lp_float", bus_b.data_oe, 12'h000);
    tick(2);
    check("lp_sts_lo", 12'(bus_b.conv_status), 12'h000);
    tick(4);
    check("lp_sts_hi", 12'(bus_b.conv_status), 12'h001);
    // restart in mid-cycle must not stretch it
    drive(5'h11);
    tick(1);
    drive(5'h15);
    k = 0;
    while (bus_b.data_oe == 12'h000 && k < 400)
    begin
      tick(1);
      k++;
    end
    check("lp_early", 12'(bus_b.conv_status), 12'h001);
    conv_len(FULL_STEPS, 9 + k, "lp_len");
    check("lp_oe", bus_b.data_oe, 12'hFFF);
    check("lp_data", bus_b.data_out, 12'hFFF);
    $display("t_low_pulse over");
  endtask
  task automatic t_high_pulse();
    comp_b = 1'b0;
    drive(5'h11);
    tick(3);
    check("hp_float", bus_b.data_oe, 12'h000);
    conv_len(FULL_STEPS, 3, "hp_len");
    tick(4);
    check("hp_idle", bus_b.data_oe, 12'h000);
    drive(5'h15);
    tick(2);
    check("hp_oe", bus_b.data_oe, 12'hFFF);
    check("hp_data", bus_b.data_out, 12'h000);
    drive(5'h11);
    tick(2);
    check("hp_off", bus_b.data_oe, 12'h000);
    conv_len(FULL_STEPS, 2, "hp_len2");
    $display("t_high_pulse over");
  endtask
  initial
  begin
    rst_n = 1'b0;
    go = 1'b0;
    short_conv = 1'b0;
    word_mode = 1'b0;
    comp_a = 1'b1;
    comp_b = 1'b1;
    drive(5'h09);
    tick(16);
    rst_n = 1'b1;
    tick(2);
    check("idle_sts", 12'(bus_b.conv_status), 12'h000);
    check("idle_oe", bus_b.data_oe, 12'h000);
    t_host();
    t_select();
    t_low_pulse();
    t_high_pulse();
    conclude();
  end
endmodule
